// *** design/eeprom_array.sv ***
// byte storage array with registered read data
`timescale 1ns/1ps
module eeprom_array #(parameter int AW = 8, parameter int DW = 8) (
  input wire logic core_clk,
  input wire logic rst_n,
  mem_if.mem bus
);
  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (bus.wr_en) begin
      cells[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus.rd_data <= '0;
    end else begin
      bus.rd_data <= cells[bus.rd_addr];
    end
  end
endmodule

// *** design/eeprom_rd_pkg.sv ***
// constants and types for the two-wire eeprom read engine
package eeprom_rd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SYNC_W = 5;
  localparam int SCL_BIT = 0;
  localparam int SDA_BIT = 1;
  localparam int CS_LO_BIT = 2;
  localparam int CS_HI_BIT = 4;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h03;
  localparam int CODE_HI = 7;
  localparam int CODE_LO = 4;
  localparam int CSEL_HI = 3;
  localparam int CSEL_LO = 1;
  localparam int RW_POS = 0;
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [ADDR_W-1:0] PTR_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_TOP = 8'hFF;
  localparam logic [ADDR_W-1:0] PTR_STEP = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  typedef enum {ST_IDLE, ST_CTRL, ST_CTRL_ACK, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_TX, ST_TX_ACK, ST_IGNORE} state_t;
endpackage

// *** design/mem_if.sv ***
// read and load port between the engine and its storage array
`timescale 1ns/1ps
interface mem_if #(parameter int AW = 8, parameter int DW = 8);
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  modport host(output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem(input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// *** design/serial_eeprom_read_engine.sv ***
// two-wire eeprom slave: control byte, word address, current/random/sequential reads
`timescale 1ns/1ps
module serial_eeprom_read_engine (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [2:0] chip_select_pins,
  input wire logic prog_busy,
  input wire logic load_en,
  input wire logic [eeprom_rd_pkg::ADDR_W-1:0] load_addr,
  input wire logic [eeprom_rd_pkg::DATA_W-1:0] load_data,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [eeprom_rd_pkg::ADDR_W-1:0] addr_ptr
);
  import eeprom_rd_pkg::*;

  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] filt;
  logic [SYNC_W-1:0] prev;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic addr_done;
  state_t state;
  logic [3:0] cnt;
  logic [DATA_W-1:0] shift;
  logic drive;
  logic rw;
  logic master_ack;
  logic [ADDR_W-1:0] ptr;

  mem_if #(.AW(ADDR_W), .DW(DATA_W)) mbus();

  eeprom_array #(.AW(ADDR_W), .DW(DATA_W)) u_array (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bus(mbus.mem)
  );

  assign mbus.rd_addr = ptr;
  assign mbus.wr_en = load_en;
  assign mbus.wr_addr = load_addr;
  assign mbus.wr_data = load_data;

  function automatic logic ctrl_match(input logic [DATA_W-1:0] b, input logic [2:0] cs);
    ctrl_match = (b[CODE_HI:CODE_LO] == CTRL_CODE) && (b[CSEL_HI:CSEL_LO] == cs);
  endfunction

  // three-stage sampling of the bus pins and straps
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1 <= SYNC_RESET;
      s2 <= SYNC_RESET;
      s3 <= SYNC_RESET;
    end else begin
      s1 <= {chip_select_pins, sda_in, scl_in};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts once stages two and three agree
  for (genvar i = 0; i < SYNC_W; i++) begin : g_filt
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        filt[i] <= SYNC_RESET[i];
      end else if (s2[i] == s3[i]) begin
        filt[i] <= s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev <= SYNC_RESET;
    end else begin
      prev <= filt;
    end
  end

  assign scl_rise = filt[SCL_BIT] && !prev[SCL_BIT];
  assign scl_fall = !filt[SCL_BIT] && prev[SCL_BIT];
  assign start_det = filt[SCL_BIT] && prev[SCL_BIT] && !filt[SDA_BIT] && prev[SDA_BIT];
  assign stop_det = filt[SCL_BIT] && prev[SCL_BIT] && filt[SDA_BIT] && !prev[SDA_BIT];
  assign byte_done = scl_fall && (cnt == BYTE_BITS);
  assign addr_done = (state == ST_ADDR) && byte_done && !prog_busy;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      shift <= DATA_ZERO;
      drive <= 1'b0;
      rw <= 1'b0;
      master_ack <= 1'b0;
    end else if (start_det) begin
      // a repeated start abandons any write in progress
      state <= ST_CTRL;
      cnt <= CNT_ZERO;
      drive <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      drive <= 1'b0;
    end else begin
      case (state)
        ST_CTRL, ST_ADDR: begin
          if (scl_rise) begin
            shift <= {shift[DATA_W-2:0], filt[SDA_BIT]};
            cnt <= cnt + CNT_ONE;
          end else if (byte_done) begin
            if (prog_busy) begin
              state <= ST_IGNORE;
            end else if (state == ST_ADDR) begin
              state <= ST_ADDR_ACK;
              drive <= 1'b1;
            end else if (ctrl_match(shift, filt[CS_HI_BIT:CS_LO_BIT])) begin
              state <= ST_CTRL_ACK;
              drive <= 1'b1;
              rw <= shift[RW_POS];
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_CTRL_ACK: begin
          if (scl_fall) begin
            cnt <= CNT_ZERO;
            if (rw) begin
              state <= ST_TX;
              shift <= mbus.rd_data;
              drive <= !mbus.rd_data[DATA_W-1];
            end else begin
              state <= ST_ADDR;
              drive <= 1'b0;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            state <= ST_WDATA;
            drive <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt == LAST_BIT) begin
              state <= ST_TX_ACK;
              drive <= 1'b0;
            end else begin
              cnt <= cnt + CNT_ONE;
              shift <= {shift[DATA_W-2:0], 1'b0};
              drive <= !shift[DATA_W-2];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            master_ack <= !filt[SDA_BIT];
          end else if (scl_fall) begin
            if (master_ack) begin
              state <= ST_TX;
              cnt <= CNT_ZERO;
              shift <= mbus.rd_data;
              drive <= !mbus.rd_data[DATA_W-1];
            end else begin
              state <= ST_IGNORE;
              drive <= 1'b0;
            end
          end
        end
        ST_IDLE, ST_WDATA, ST_IGNORE: begin
          drive <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          drive <= 1'b0;
        end
      endcase
    end
  end

  // shared pointer: loaded by a word address, stepped after each byte sent
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr <= PTR_RESET;
    end else if (addr_done) begin
      ptr <= shift;
    end else if ((state == ST_TX) && scl_fall && (cnt == LAST_BIT)) begin
      ptr <= ptr + PTR_STEP;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      addr_ptr <= PTR_RESET;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= !drive;
      addr_ptr <= ptr;
    end
  end

  property p_ctrl_code;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_CTRL_ACK) |-> $past(shift[CODE_HI:CODE_LO]) == CTRL_CODE;
  endproperty
  a_ctrl_code: assert property (p_ctrl_code) else $error("ack given to wrong device code");

  property p_ctrl_cs;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_CTRL_ACK) |-> $past(shift[CSEL_HI:CSEL_LO]) == $past(filt[CS_HI_BIT:CS_LO_BIT]);
  endproperty
  a_ctrl_cs: assert property (p_ctrl_cs) else $error("ack given with chip select mismatch");

  property p_busy_no_ack;
    @(posedge core_clk) disable iff (!rst_n)
    (prog_busy && byte_done && (state == ST_CTRL || state == ST_ADDR) && !start_det && !stop_det)
      |=> state == ST_IGNORE ##1 sda_oe_n;
  endproperty
  a_busy_no_ack: assert property (p_busy_no_ack) else $error("byte acknowledged while busy");

  property p_ack_drives;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_CTRL_ACK) |=> !sda_oe_n;
  endproperty
  a_ack_drives: assert property (p_ack_drives) else $error("control byte ack not driven low");

  property p_read_dir;
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(state == ST_TX) && $past(state) == ST_CTRL_ACK) |-> rw;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("data sent without read direction");

  property p_first_byte;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_TX) |-> (shift == $past(mbus.rd_data)) && ($past(mbus.rd_addr) == ptr);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("byte not taken from pointer location");

  property p_ptr_step;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_TX_ACK) |-> ptr == ($past(ptr) + PTR_STEP);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step by one");

  property p_ptr_wrap;
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(state == ST_TX_ACK) && $past(ptr) == PTR_TOP) |-> ##2 addr_ptr == PTR_RESET;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap to zero");

  property p_addr_load;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_ADDR_ACK) |-> ptr == $past(shift);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("word address not loaded");

  property p_nack_release;
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(state == ST_IGNORE) && $past(state) == ST_TX_ACK) |=> sda_oe_n [*2];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("line not released after nack");

  property p_stop_release;
    @(posedge core_clk) disable iff (!rst_n)
    stop_det |-> ##2 sda_oe_n;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("line still driven after stop");

  property p_seq_next;
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(state == ST_TX) && $past(state) == ST_TX_ACK) |-> $past(master_ack);
  endproperty
  a_seq_next: assert property (p_seq_next) else $error("next byte sent without master ack");
endmodule

// *** dv/tb.sv ***
// self-checking bench for the two-wire eeprom read engine
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  compares += 1; \
  if ((gt) !== (ex)) begin \
    mismatches += 1; \
    $display("unexpected %s exp %h got %h", nm, ex, gt); \
  end
module tb;
  import eeprom_rd_pkg::*;
  logic core_clk;
  logic rst_n = 1'b0;
  logic [2:0] chip_select_pins = 3'h0;
  logic prog_busy = 1'b0;
  logic load_en = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic sda_out, sda_oe_n, scl, sda_m, rx_stb, sda_w;
  logic [7:0] addr_ptr;
  logic [8:0] rx_val, e;
  logic [7:0] mem [256];
  logic [8:0] exp_q [$];
  logic [7:0] rnd = 8'h06;
  logic [2:0] cs;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  assign sda_w = (sda_oe_n == 1'b0) ? sda_out : sda_m;
  serial_eeprom_read_engine dut_u (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .chip_select_pins(chip_select_pins), .prog_busy(prog_busy), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_ptr(addr_ptr));
  twi_master_model mst_u (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m), .rx_stb(rx_stb),
    .rx_val(rx_val));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] ctl(input logic [3:0] code, input logic [2:0] c, input logic rw);
    return {code, c, rw};
  endfunction
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // note the expected result, then run the byte on the bus
  task automatic op(input logic [7:0] d, input logic rd, input logic nack, input logic [8:0] ex);
    exp_q.push_back(ex);
    mst_u.xfer(d, rd, nack);
  endtask
  task automatic endchk(input string nm, input logic [7:0] p);
    @(negedge core_clk);
    `CHK("addr_ptr", p, addr_ptr)
    `CHK("sda_oe_n", 1'b1, sda_oe_n)
    $display("test %0s done", nm);
  endtask
  // result watcher: oldest note against each finished byte
  always @(posedge core_clk) begin
    if (rx_stb === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'hXXX;
      `CHK("byte", e, rx_val)
    end
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches += 1;
      finish_test();
    end
  end
  initial begin
    repeat (19) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("reset addr_ptr", PTR_RESET, addr_ptr)
    @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 256; a++) begin
      @(posedge core_clk);
      rnd = lfsr(rnd);
      mem[a] = rnd;
      load_en <= 1'b1;
      load_addr <= a[7:0];
      load_data <= rnd;
    end
    @(posedge core_clk);
    load_en <= 1'b0;
    cs = rnd[2:0];
    chip_select_pins <= cs;
    repeat (20) @(posedge core_clk);
    mst_u.start();
    op(ctl(CTRL_CODE, cs, 1'b0), 1'b0, 1'b0, {1'b0, ctl(CTRL_CODE, cs, 1'b0)});
    op(8'hFE, 1'b0, 1'b0, {1'b0, 8'hFE});
    mst_u.start();
    op(ctl(CTRL_CODE, cs, 1'b1), 1'b0, 1'b0, {1'b0, ctl(CTRL_CODE, cs, 1'b1)});
    op(8'h00, 1'b1, 1'b0, {1'b0, mem[8'hFE]});
    op(8'h00, 1'b1, 1'b0, {1'b0, mem[8'hFF]});
    op(8'h00, 1'b1, 1'b1, {1'b0, mem[8'h00]});
    mst_u.stop();
    endchk("random_sequential", 8'h01);
    mst_u.start();
    op(ctl(CTRL_CODE, cs, 1'b1), 1'b0, 1'b0, {1'b0, ctl(CTRL_CODE, cs, 1'b1)});
    op(8'h00, 1'b1, 1'b1, {1'b0, mem[8'h01]});
    mst_u.stop();
    endchk("current", 8'h02);
    // wrong code, wrong chip select, busy programming: each left unanswered
    for (int k = 0; k < 3; k++) begin
      mst_u.start();
      prog_busy <= (k == 2);
      op(ctl(k == 0 ? 4'hB : CTRL_CODE, k == 1 ? cs ^ 3'h1 : cs, 1'b1), 1'b0, 1'b0,
        {1'b1, ctl(k == 0 ? 4'hB : CTRL_CODE, k == 1 ? cs ^ 3'h1 : cs, 1'b1)});
      mst_u.stop();
      prog_busy <= 1'b0;
      endchk("refused", 8'h02);
    end
    // single-byte random read at a random word, ended by nack and stop
    rnd = lfsr(rnd);
    mst_u.start();
    op(ctl(CTRL_CODE, cs, 1'b0), 1'b0, 1'b0, {1'b0, ctl(CTRL_CODE, cs, 1'b0)});
    op(rnd, 1'b0, 1'b0, {1'b0, rnd});
    mst_u.start();
    op(ctl(CTRL_CODE, cs, 1'b1), 1'b0, 1'b0, {1'b0, ctl(CTRL_CODE, cs, 1'b1)});
    op(8'h00, 1'b1, 1'b1, {1'b0, mem[rnd]});
    mst_u.stop();
    endchk("random", rnd + 8'h01);
    // word address arriving while programming: no ack and the pointer is left alone
    mst_u.start();
    op(ctl(CTRL_CODE, cs, 1'b0), 1'b0, 1'b0, {1'b0, ctl(CTRL_CODE, cs, 1'b0)});
    prog_busy <= 1'b1;
    op(~rnd, 1'b0, 1'b0, {1'b1, ~rnd});
    mst_u.stop();
    prog_busy <= 1'b0;
    endchk("busy_addr", rnd + 8'h01);
    repeat (4) @(posedge core_clk);
    `CHK("notes left", 0, exp_q.size())
    finish_test();
  end
endmodule

// *** dv/twi_master_model.sv ***
// two-wire bus master model facing the eeprom read engine
`timescale 1ns/1ps
module twi_master_model (
  input wire logic core_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m,
  output logic rx_stb,
  output logic [8:0] rx_val
);
  // idle bus: both lines released high, clock stands still
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    rx_stb = 1'b0;
    rx_val = 9'h000;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one clock pulse; sda moves only while scl is low
  task automatic bitx(input logic b, output logic s);
    wt(8);
    sda_m <= b;
    wt(4);
    scl <= 1'b1;
    wt(8);
    s = sda_w;
    wt(5);
    scl <= 1'b0;
  endtask
  task automatic start();
    wt(8);
    sda_m <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_m <= 1'b0;
    wt(8);
    scl <= 1'b0;
  endtask
  task automatic stop();
    wt(8);
    sda_m <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_m <= 1'b1;
    wt(8);
  endtask
  // sends d, or with rd set releases sda and collects a byte; ack slot last
  task automatic xfer(input logic [7:0] d, input logic rd, input logic nack);
    logic [7:0] got;
    logic s;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitx(rd | d[i], s);
      got[i] = s;
    end
    bitx(rd ? nack : 1'b1, a);
    rx_val <= rd ? {1'b0, got} : {a, d};
    rx_stb <= 1'b1;
    wt(1);
    rx_stb <= 1'b0;
  endtask
endmodule
